// ===== design/pms_sequencer.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module pms_sequencer (
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire logic [3:0]            regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [31:0]           regRdata,
    input  wire pms_pkg::pms_core_req_t coreReq,
    input  wire logic [7:0]            intFlags,
    output logic                       cpuClkEn,
    output logic                       periphClkEn,
    output logic                       primaryOscEn,
    output logic                       intOscEn,
    output logic                       rcSourceEn,
    output logic                       useIntMux,
    output logic                       wdtClear,
    output logic                       wdtReset,
    output logic                       branchVector
);
    // ==========================================================
    // Registers and decode.
    logic [31:0]        ctrl;
    logic [31:0]        cfg;
    logic [7:0]         intEn;
    logic               stableFlag;
    logic               startFlag;
    logic               startupHold;
    logic [pms_pkg::CNT_W-1:0] stabCnt;
    logic [pms_pkg::CNT_W-1:0] wakeCnt;
    pms_pkg::pms_mode_t mode;
    pms_pkg::pms_mode_t next_mode;

    wire wrCtrl   = regWr && (regAddr == pms_pkg::OFF_CTRL);
    wire wrIntEn  = regWr && (regAddr == pms_pkg::OFF_INTEN);
    wire wrCfg    = regWr && (regAddr == pms_pkg::OFF_CFG);
    wire [2:0] internal_freq_select   = ctrl[pms_pkg::CTRL_INTERNAL_FREQ_SELECT_LSB +: 3];
    wire [2:0] newIrcf = regWdata[pms_pkg::CTRL_INTERNAL_FREQ_SELECT_LSB +: 3];
    wire low_freq_source_select   = ctrl[pms_pkg::CTRL_LOW_FREQ_SOURCE_SELECT];
    wire idle_enable_bit    = ctrl[pms_pkg::CTRL_IDLE_ENABLE_BIT];
    // Select-lo is stored for software but never steers the mux.
    wire scsHi    = ctrl[pms_pkg::CTRL_SCS_HI];
    wire wdtEn    = cfg[pms_pkg::CFG_WDTEN];
    wire fscmEn   = cfg[pms_pkg::CFG_FSCM];
    wire iesoEn   = cfg[pms_pkg::CFG_IESO];
    wire gie      = intEn[pms_pkg::INT_GIE];
    wire oscReq   = (internal_freq_select != 3'h0) || low_freq_source_select;
    wire intWake  = |(intFlags[6:0] & intEn[6:0]);
    wire asleep   = (mode == pms_pkg::PMS_IDLE) || (mode == pms_pkg::PMS_SLEEP);
    wire wakeEvt  = asleep && (intWake || coreReq.wdtTimeout);
    wire startupFast = (fscmEn || iesoEn) && startupHold;
    wire onIntMux = scsHi || startupFast;
    wire ircfWrite = wrCtrl && onIntMux && (newIrcf != internal_freq_select);
    wire wakeDone = (mode == pms_pkg::PMS_WAKE) &&
                    (wakeCnt == pms_pkg::CNT_W'(pms_pkg::WAKE_PREP_CYC - 1));
    wire stableDone = stabCnt == pms_pkg::CNT_W'(pms_pkg::OSC_STABLE_CYC - 1);

    // ==========================================================
    // Mode sequencing.
    always_comb begin
        next_mode = mode;
        unique case (mode)
            pms_pkg::PMS_RUN: begin
                if (coreReq.sleepExec && !startupHold) begin
                    next_mode = idle_enable_bit ? pms_pkg::PMS_IDLE : pms_pkg::PMS_SLEEP;
                end
            end
            pms_pkg::PMS_IDLE, pms_pkg::PMS_SLEEP: begin
                if (wakeEvt) begin
                    next_mode = pms_pkg::PMS_WAKE;
                end
            end
            pms_pkg::PMS_WAKE: begin
                if (wakeDone) begin
                    next_mode = pms_pkg::PMS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= pms_pkg::PMS_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wakeCnt <= '0;
        end else if (mode == pms_pkg::PMS_WAKE) begin
            wakeCnt <= wakeCnt + 1'b1;
        end else begin
            wakeCnt <= '0;
        end
    end

    // ==========================================================
    // Software registers. Wake-up never touches ctrl.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl  <= pms_pkg::CTRL_RESET;
            cfg   <= pms_pkg::CFG_RESET;
            intEn <= pms_pkg::INTEN_RST;
        end else begin
            if (wrCtrl) begin
                ctrl <= regWdata;
            end
            if (wrCfg) begin
                cfg <= regWdata;
            end
            if (wrIntEn) begin
                intEn <= regWdata[7:0];
            end
        end
    end

    // ==========================================================
    // Oscillator stability tracking. A running, stable oscillator keeps its flag.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stabCnt    <= '0;
            stableFlag <= 1'b0;
        end else if (!oscReq) begin
            stabCnt    <= '0;
            stableFlag <= 1'b0;
        end else if (!stableFlag) begin
            stabCnt    <= stabCnt + 1'b1;
            stableFlag <= stableDone;
        end
    end

    // ==========================================================
    // Start-up hold and start-timer flag.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            startupHold <= 1'b1;
            startFlag   <= 1'b0;
        end else if (startupHold && coreReq.primaryReady && !scsHi) begin
            startupHold <= 1'b0;
            startFlag   <= 1'b1;
        end else if (startupHold && (scsHi || (startupFast && coreReq.sleepExec))) begin
            startupHold <= 1'b0;
            startFlag   <= 1'b0;
        end else if (scsHi) begin
            startFlag   <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs, all registered.
    wire cpuRun = (mode == pms_pkg::PMS_RUN) && (!startupHold || startupFast);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpuClkEn     <= 1'b0;
            periphClkEn  <= 1'b0;
            primaryOscEn <= 1'b1;
            intOscEn     <= 1'b0;
            rcSourceEn   <= 1'b0;
            useIntMux    <= 1'b0;
            wdtClear     <= 1'b0;
            wdtReset     <= 1'b0;
            branchVector <= 1'b0;
            regRdata     <= 32'h0000_0000;
        end else begin
            cpuClkEn     <= cpuRun;
            periphClkEn  <= (mode != pms_pkg::PMS_SLEEP);
            primaryOscEn <= !scsHi && !(startupFast && coreReq.sleepExec);
            intOscEn     <= oscReq;
            rcSourceEn   <= wdtEn || fscmEn;
            useIntMux    <= onIntMux;
            wdtClear     <= coreReq.sleepExec || coreReq.clrwdtExec ||
                            (coreReq.clockLoss && fscmEn) || ircfWrite;
            wdtReset     <= coreReq.wdtTimeout && !asleep;
            branchVector <= wakeEvt && intWake && gie;
            unique case (1'b1)
                regRd && regAddr == pms_pkg::OFF_CTRL:   regRdata <= ctrl;
                regRd && regAddr == pms_pkg::OFF_STATUS:
                    regRdata <= {26'h0, mode, startupHold, intOscEn, startFlag, stableFlag};
                regRd && regAddr == pms_pkg::OFF_INTEN:  regRdata <= {24'h0, intEn};
                regRd && regAddr == pms_pkg::OFF_CFG:    regRdata <= cfg;
                default:                                  regRdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Checks.
    a_wake_needs_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mode == pms_pkg::PMS_WAKE) |-> $past(intWake || coreReq.wdtTimeout))
        else $error("wake without cause");
    a_wake_delay: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(mode == pms_pkg::PMS_WAKE) |-> (mode == pms_pkg::PMS_WAKE)[*2]
        ##1 mode == pms_pkg::PMS_RUN)
        else $error("wake prep delay wrong");
    a_osc_enable: assert property (@(posedge mclk) disable iff (!rst_b)
        oscReq |=> intOscEn)
        else $error("oscillator not enabled");
    a_osc_off_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        !oscReq |=> !stableFlag)
        else $error("stable flag with oscillator off");
    a_stable_delay: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(oscReq) && !stableFlag |-> ##2 (!stableFlag)[*8] ##1 stableFlag)
        else $error("stable delay wrong");
    a_stable_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        stableFlag && oscReq && coreReq.sleepExec |=> stableFlag)
        else $error("stable flag lost at idle entry");
    a_wdt_reset_run: assert property (@(posedge mclk) disable iff (!rst_b)
        coreReq.wdtTimeout |=> (wdtReset == !$past(asleep)))
        else $error("watchdog action wrong");
    a_idle_cpu_off: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == pms_pkg::PMS_IDLE |=> !cpuClkEn && periphClkEn)
        else $error("idle clocks wrong");
    a_rc_running: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdtEn || fscmEn) |=> rcSourceEn)
        else $error("rc source stopped");
    a_sleep_wdt_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        coreReq.sleepExec |=> wdtClear)
        else $error("watchdog not cleared");

    // ==========================================================
    // Checks on start-up, clock source and wake-up.
    a_hold_cpu_off: assert property (@(posedge mclk) disable iff (!rst_b)
        startupHold && !startupFast |=> !cpuClkEn)
        else $error("processor clocked during start-up hold");
    a_mux_start_clr: assert property (@(posedge mclk) disable iff (!rst_b)
        scsHi |=> !startFlag)
        else $error("start flag kept on internal mux");
    a_mux_primary_off: assert property (@(posedge mclk) disable iff (!rst_b)
        scsHi |=> !primaryOscEn)
        else $error("primary oscillator kept on internal mux");
    a_wake_ctrl_kept: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == pms_pkg::PMS_WAKE) && !wrCtrl |=> $stable(ctrl))
        else $error("control bits changed by wake-up");
    a_branch_needs_gie: assert property (@(posedge mclk) disable iff (!rst_b)
        branchVector |-> $past(gie && intWake))
        else $error("vector branch without global enable");
    a_sleep_periph_off: assert property (@(posedge mclk) disable iff (!rst_b)
        mode == pms_pkg::PMS_SLEEP |=> !periphClkEn)
        else $error("peripherals clocked in sleep");
    a_wake_cpu_on: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == pms_pkg::PMS_RUN) && ($past(mode) == pms_pkg::PMS_WAKE) |=> cpuClkEn)
        else $error("processor not restarted after wake");
    a_wake_mux_kept: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == pms_pkg::PMS_WAKE) && scsHi |=> useIntMux && periphClkEn)
        else $error("internal mux lost during wake");
    c_idle_entry: cover property (@(posedge mclk) disable iff (!rst_b)
        mode == pms_pkg::PMS_RUN ##1 mode == pms_pkg::PMS_IDLE);
    c_int_wake: cover property (@(posedge mclk) disable iff (!rst_b) wakeEvt && intWake);
    c_wdt_wake: cover property (@(posedge mclk) disable iff (!rst_b)
        wakeEvt && coreReq.wdtTimeout);
    c_branch: cover property (@(posedge mclk) disable iff (!rst_b) branchVector);
endmodule : pms_sequencer

// ===== design/pms_pkg.sv
package pms_pkg;
    // ==========================================================
    // Register map (word offsets on the plain register port).
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h1;
    localparam logic [3:0] OFF_INTEN  = 4'h2;
    localparam logic [3:0] OFF_CFG    = 4'h3;

    // ==========================================================
    // Control, configuration and interrupt-enable register field positions.
    localparam int CTRL_SCS_LO   = 0;
    localparam int CTRL_SCS_HI   = 1;
    localparam int CTRL_INTERNAL_FREQ_SELECT_LSB = 4;
    localparam int CTRL_IDLE_ENABLE_BIT    = 7;
    localparam int CTRL_LOW_FREQ_SOURCE_SELECT   = 8;
    localparam int CFG_WDTEN     = 0;
    localparam int CFG_FSCM      = 1;
    localparam int CFG_IESO      = 2;
    localparam int INT_GIE       = 7;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [7:0]  INTEN_RST  = 8'h00;

    // ==========================================================
    // Timing, 250 MHz clock.
    localparam int CLK_MHZ        = 250;
    localparam int WAKE_PREP_NS   = 8;
    localparam int OSC_STABLE_NS  = 40;
    localparam int WAKE_PREP_CYC  = (WAKE_PREP_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_STABLE_CYC = (OSC_STABLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W          = 8;

    typedef enum logic [1:0] {PMS_RUN, PMS_IDLE, PMS_SLEEP, PMS_WAKE} pms_mode_t;

    // Core-facing request group.
    typedef struct packed {
        logic sleepExec;
        logic clrwdtExec;
        logic wdtTimeout;
        logic clockLoss;
        logic primaryReady;
    } pms_core_req_t;
endpackage : pms_pkg

// ===== sim/pms_core_model.sv
`timescale 1ns/1ns
// ==========================================================
// Far side: processor core, interrupt flags and watchdog.
module pms_core_model (
    input  wire logic              mclk,
    input  wire logic              cpuClkEn,
    output pms_pkg::pms_core_req_t coreReq,
    output logic [7:0]             intFlags
);
    initial begin
        coreReq = '0;
        intFlags = 8'h00;
    end

    // Bits are sleep, clear, time-out, clock loss. Sleep and clear are
    // instructions, so a core whose clock is gated cannot issue them.
    task automatic pulse(input logic [3:0] b);
        @(posedge mclk);
        if (b[3:2] != 2'b00 && cpuClkEn !== 1'b1) return;
        coreReq <= {b, coreReq.primaryReady};
        @(posedge mclk);
        coreReq <= {4'h0, coreReq.primaryReady};
    endtask : pulse

    // Flags are levels; clearing them is software's job, not the block's.
    task automatic set_levels(input logic rdy, input logic [7:0] f);
        @(posedge mclk);
        coreReq.primaryReady <= rdy;
        intFlags <= f;
    endtask : set_levels
endmodule : pms_core_model

// ===== sim/tb_power_mode_clock_sequencer.sv
`timescale 1ns/1ns
module tb_power_mode_clock_sequencer;
    logic                   mclk, rst_b, regWr, regRd;
    logic [3:0]             regAddr;
    logic [31:0]            regWdata, regRdata, rd;
    pms_pkg::pms_core_req_t coreReq;
    logic [7:0]             intFlags;
    logic                   cpuClkEn, periphClkEn, primaryOscEn, intOscEn;
    logic                   rcSourceEn, useIntMux, wdtClear, wdtReset, branchVector;
    int                     errors, nTests, cycles, nClr, nRst, nBr, n, b0;

    pms_sequencer dut_u (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .coreReq(coreReq), .intFlags(intFlags), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .primaryOscEn(primaryOscEn), .intOscEn(intOscEn),
        .rcSourceEn(rcSourceEn), .useIntMux(useIntMux), .wdtClear(wdtClear),
        .wdtReset(wdtReset), .branchVector(branchVector));
    pms_core_model model_u (.mclk(mclk), .cpuClkEn(cpuClkEn), .coreReq(coreReq),
        .intFlags(intFlags));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ==========================================================
    // Pulse counters and hang guard.
    always @(posedge mclk) begin
        cycles++;
        nClr += int'(wdtClear === 1'b1);
        nRst += int'(wdtReset === 1'b1);
        nBr += int'(branchVector === 1'b1);
        if (cycles == 3000) begin
            errors++;
            $display("MISMATCH %0t hang", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, exp, input string msg);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : reg_read

    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : idle

    // Bounded wait for the processor clock gate to reach a level.
    task automatic wait_cpu(input logic lvl);
        n = 0;
        while (cpuClkEn !== lvl && n < 50) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask : wait_cpu

    // ==========================================================
    // Scenarios.
    task automatic t_startup;
        idle(3);
        check(32'(primaryOscEn), 32'h1, "osc rst");
        check(32'(cpuClkEn), 32'h0, "hold");
        foreach (rd[i]) if (i < 4) begin
            reg_read(4'(i));
            check(rd, (i == 1) ? 32'h8 : 32'h0, "rst val");
        end
        reg_read(4'hf);
        check(rd, 32'h0, "unmapped");
        reg_write(pms_pkg::OFF_CFG, 32'h4);
        wait_cpu(1'b1);
        check(32'(n < 5 && useIntMux === 1'b1), 32'h1, "two-speed");
        model_u.set_levels(1'b1, 8'h00);
        idle(4);
        reg_read(pms_pkg::OFF_STATUS);
        check(rd[1], 1'b1, "start flag");
    endtask : t_startup

    task automatic t_osc;
        reg_write(pms_pkg::OFF_CTRL, 32'h10);
        reg_read(pms_pkg::OFF_STATUS);
        check({intOscEn, rd[0]}, 2'b10, "osc early");
        idle(12);
        reg_read(pms_pkg::OFF_STATUS);
        check(rd[0], 1'b1, "stable");
        reg_write(pms_pkg::OFF_CTRL, 32'h0);
        reg_read(pms_pkg::OFF_STATUS);
        check({intOscEn, rd[0]}, 2'b00, "osc off");
        reg_write(pms_pkg::OFF_CTRL, 32'h100);
        idle(14);
        check(32'(intOscEn), 32'h1, "src osc");
    endtask : t_osc

    task automatic t_idle;
        reg_write(pms_pkg::OFF_CTRL, 32'h181);
        reg_write(pms_pkg::OFF_CTRL, 32'h183);
        b0 = nClr;
        model_u.pulse(4'b1000);
        idle(3);
        check({cpuClkEn, periphClkEn, useIntMux, primaryOscEn}, 4'b0110, "idle");
        check(32'(nClr - b0), 32'h1, "clr sleep");
        reg_read(pms_pkg::OFF_STATUS);
        check(rd[1:0], 2'b01, "idle flags");
        reg_write(pms_pkg::OFF_INTEN, 32'h80);
        model_u.set_levels(1'b1, 8'h01);
        idle(10);
        check(32'(cpuClkEn), 32'h0, "masked");
        b0 = nBr;
        reg_write(pms_pkg::OFF_INTEN, 32'h81);
        wait_cpu(1'b1);
        check(32'(n >= pms_pkg::WAKE_PREP_CYC && n <= pms_pkg::WAKE_PREP_CYC + 4),
            32'h1, "wake delay");
        idle(2);
        check({periphClkEn, useIntMux}, 2'b11, "wake mux");
        check(32'(nBr - b0), 32'h1, "vector");
        model_u.set_levels(1'b1, 8'h00);
        reg_read(pms_pkg::OFF_CTRL);
        check(rd, 32'h183, "ctrl kept");
    endtask : t_idle

    task automatic t_sleep;
        reg_write(pms_pkg::OFF_INTEN, 32'h01);
        reg_write(pms_pkg::OFF_CTRL, 32'h100);
        b0 = nRst;
        model_u.pulse(4'b1000);
        idle(3);
        check({cpuClkEn, periphClkEn}, 2'b00, "sleep");
        model_u.pulse(4'b0010);
        wait_cpu(1'b1);
        check(32'(nRst - b0 == 0 && n < 10), 32'h1, "wdt wake");
        b0 = nBr;
        model_u.pulse(4'b1000);
        model_u.set_levels(1'b1, 8'h01);
        wait_cpu(1'b1);
        idle(2);
        check(32'(nBr - b0 == 0 && n < 10), 32'h1, "no vector");
        model_u.set_levels(1'b1, 8'h00);
        b0 = nRst;
        model_u.pulse(4'b0010);
        idle(2);
        check(32'(nRst - b0), 32'h1, "wdt reset");
        b0 = nClr;
        model_u.pulse(4'b0100);
        reg_write(pms_pkg::OFF_CFG, 32'h3);
        model_u.pulse(4'b0001);
        idle(2);
        check(32'(nClr - b0), 32'h2, "wdt clears");
        check(32'(rcSourceEn), 32'h1, "rc on");
    endtask : t_sleep

    task automatic print_verdict;
        if (errors == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        {rst_b, regWr, regRd, regAddr, regWdata} = '0;
        {errors, nTests, cycles, nClr, nRst, nBr} = '0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_startup();
        t_osc();
        t_idle();
        t_sleep();
        print_verdict();
    end
endmodule : tb_power_mode_clock_sequencer
